// ===== hdl/fpwm_consts.svh
// Constants for the frame PWM output unit: offsets, fields, resets, timing.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
`ifndef FPWM_CONSTS_SVH
`define FPWM_CONSTS_SVH

`define FPWM_IDX_FRAME_LENGTH   16'hFED4
`define FPWM_IDX_PULSE_WIDTH    16'hFED5
`define FPWM_IDX_IRQ_STATUS     16'hFED6
`define FPWM_IDX_IRQ_MASK       16'hFED7
`define FPWM_IDX_UNIT_STATUS    16'hFED8
`define FPWM_ADDR_W             18
`define FPWM_RST_SETTING        8'h00
`define FPWM_MIN_FRAME          8'h02
`define FPWM_STAT_FRAME_BIT     0
`define FPWM_USTAT_OUT_BIT      0
`define FPWM_USTAT_PDN_BIT      1
`define FPWM_USTAT_OSC_BIT      2
`define FPWM_CLK_HZ             25000000
`define FPWM_OSC_HZ             370000
`define FPWM_OSC_HALF_CYC       ((`FPWM_CLK_HZ) / (2 * (`FPWM_OSC_HZ)))

`endif

// ===== hdl/fpwm_osc.sv
// Start-up oscillator, running only while i_run is high: square wave by half-period counter.
// Assumes one synchronous clock and an active-high synchronous reset.
`include "fpwm_consts.svh"
`default_nettype none
module fpwm_osc #(
  parameter int HALF_CYC = `FPWM_OSC_HALF_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_run,
  output logic      o_wave
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       wave;
  } fpwm_osc_st_t;

  localparam logic [7:0] LAST = 8'(HALF_CYC - 1);

  fpwm_osc_st_t s_r;
  fpwm_osc_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!i_run) begin
      s_nxt.cnt  = 8'h00;
      s_nxt.wave = 1'b0;
    end else if (s_r.cnt == LAST) begin
      s_nxt.cnt  = 8'h00;
      s_nxt.wave = ~s_r.wave;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_wave = s_r.wave;
endmodule
`default_nettype wire

// ===== hdl/fpwm_pkg.sv
// Types for the frame PWM output unit.
// Assumes fpwm_consts.svh is compiled alongside.
`default_nettype none
package fpwm_pkg;
  typedef enum logic [2:0] {
    FPWM_PDN = 3'h1,
    FPWM_RUN = 3'h2,
    FPWM_OSC = 3'h4
  } fpwm_mode_t;
endpackage
`default_nettype wire

// ===== hdl/fpwm_top.sv
// Frame PWM output unit with Avalon-MM registers and frame interrupt.
// Assumes synchronous inputs, 25 MHz clock, active-high synchronous reset.
//
// Decided for this implementation: the Avalon-MM slave port.
`include "fpwm_consts.svh"
`default_nettype none
module fpwm_top
  import fpwm_pkg::*;
#(
  parameter int OSC_HALF = `FPWM_OSC_HALF_CYC
) (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset,
  input  wire logic [`FPWM_ADDR_W-1:0] i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [31:0]             o_avs_readdata,
  output logic                         o_avs_waitrequest,
  output logic      [1:0]              o_avs_response,
  input  wire logic                    i_power_button_pin,
  output logic                         o_pwm,
  output logic                         o_pwm_oe,
  output logic                         o_frame_start,
  output logic                         o_irq
);
  import fpwm_pkg::*;

  typedef struct packed {
    fpwm_mode_t  mode;
    logic [7:0]  frame_hold;
    logic [7:0]  pulse_hold;
    logic [7:0]  frame_work;
    logic [7:0]  pulse_work;
    logic [7:0]  cnt;
    logic        out;
    logic        fstart;
    logic        stat;
    logic        mask;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  resp;
  } fpwm_st_t;

  fpwm_st_t s_r;
  fpwm_st_t s_nxt;
  logic     osc_wave;

  fpwm_osc #(
    .HALF_CYC (OSC_HALF)
  ) u_osc (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_run     (i_power_button_pin),
    .o_wave    (osc_wave)
  );

  logic [15:0] word_idx;
  logic        req;
  logic        wr_lo;
  logic        frame_ok;
  logic        pulse_hi;

  assign word_idx = i_avs_address[`FPWM_ADDR_W-1:2];
  assign req      = (i_avs_read | i_avs_write) & ~s_r.ack;
  assign wr_lo    = i_avs_write & i_avs_byteenable[0];

  always_comb begin
    s_nxt        = s_r;
    s_nxt.fstart = 1'b0;
    s_nxt.ack    = 1'b0;
    frame_ok     = 1'b0;
    pulse_hi     = 1'b0;

    // Register access, answered one cycle after the request
    if (req) begin
      s_nxt.ack   = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      s_nxt.resp  = 2'h0;
      case (word_idx)
        `FPWM_IDX_FRAME_LENGTH: begin
          if (wr_lo) begin
            s_nxt.frame_hold = i_avs_writedata[7:0];
          end
          s_nxt.rdata[7:0] = s_r.frame_hold;
        end
        `FPWM_IDX_PULSE_WIDTH: begin
          if (wr_lo) begin
            s_nxt.pulse_hold = i_avs_writedata[7:0];
          end
          s_nxt.rdata[7:0] = s_r.pulse_hold;
        end
        `FPWM_IDX_IRQ_STATUS: begin
          s_nxt.rdata[`FPWM_STAT_FRAME_BIT] = s_r.stat;
          if (wr_lo && i_avs_writedata[`FPWM_STAT_FRAME_BIT]) begin
            s_nxt.stat = 1'b0;
          end
        end
        `FPWM_IDX_IRQ_MASK: begin
          if (wr_lo) begin
            s_nxt.mask = i_avs_writedata[`FPWM_STAT_FRAME_BIT];
          end
          s_nxt.rdata[`FPWM_STAT_FRAME_BIT] = s_r.mask;
        end
        `FPWM_IDX_UNIT_STATUS: begin
          s_nxt.rdata[`FPWM_USTAT_OUT_BIT] = s_r.out;
          s_nxt.rdata[`FPWM_USTAT_PDN_BIT] = (s_r.mode == FPWM_PDN);
          s_nxt.rdata[`FPWM_USTAT_OSC_BIT] = (s_r.mode == FPWM_OSC);
        end
        default: begin
          s_nxt.resp = 2'h2;
        end
      endcase
    end

    // Generator
    case (s_r.mode)
      FPWM_PDN: begin
        s_nxt.out = 1'b0;
        s_nxt.cnt = 8'h00;
        if (i_power_button_pin) begin
          s_nxt.mode = FPWM_OSC;
        end else if (s_r.frame_hold >= `FPWM_MIN_FRAME) begin
          frame_ok = 1'b1;
        end
      end
      FPWM_RUN: begin
        if (i_power_button_pin) begin
          s_nxt.mode = FPWM_OSC;
        end else if (s_r.cnt == s_r.frame_work - 8'h01) begin
          // Frame boundary: take the buffered values
          if (s_r.frame_hold < `FPWM_MIN_FRAME) begin
            s_nxt.mode = FPWM_PDN;
            s_nxt.out  = 1'b0;
          end else begin
            frame_ok = 1'b1;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 8'h01;
          pulse_hi  = (s_r.pulse_work > s_r.frame_work) ||
                      (s_nxt.cnt < s_r.pulse_work);
          s_nxt.out = pulse_hi;
        end
      end
      FPWM_OSC: begin
        s_nxt.out = 1'b0;
        s_nxt.cnt = 8'h00;
        if (!i_power_button_pin) begin
          s_nxt.mode = FPWM_PDN;
        end
      end
      default: begin
        s_nxt.mode = FPWM_PDN;
      end
    endcase

    if (frame_ok) begin
      s_nxt.mode       = FPWM_RUN;
      s_nxt.cnt        = 8'h00;
      s_nxt.frame_work = s_r.frame_hold;
      s_nxt.pulse_work = s_r.pulse_hold;
      s_nxt.fstart     = 1'b1;
      s_nxt.out        = (s_r.pulse_hold != 8'h00);
    end

    // Sticky frame status; set wins over a write-one clear
    if (s_nxt.fstart) begin
      s_nxt.stat = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r      <= '0;
      s_r.mode <= FPWM_PDN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~s_r.ack;
  assign o_avs_readdata    = s_r.rdata;
  assign o_avs_response    = s_r.resp;
  assign o_frame_start     = s_r.fstart;
  assign o_irq             = s_r.stat & s_r.mask;
  assign o_pwm             = (s_r.mode == FPWM_OSC) ? 1'b0 : s_r.out;
  // Oscillation is open drain: drive low on low half, pull-up on high half
  assign o_pwm_oe          = (s_r.mode == FPWM_OSC) ? ~osc_wave : 1'b1;

  a_pdn_low: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_r.mode == FPWM_PDN) |-> !o_pwm)
    else $error("output high in powerdown");

  sequence s_frame_begin;
    (s_r.fstart && s_r.mode == FPWM_RUN && !i_power_button_pin);
  endsequence

  a_frame_period: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_frame_begin ##1 (!s_r.fstart && s_r.mode == FPWM_RUN)
      [*1] |-> (s_r.cnt == 8'h01))
    else $error("counter did not advance after frame start");

  a_pulse_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_r.mode == FPWM_RUN && s_r.pulse_work == 8'h00) |-> !o_pwm)
    else $error("output high with zero pulse");

  a_pulse_over: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_r.mode == FPWM_RUN && s_r.pulse_work > s_r.frame_work) |-> o_pwm)
    else $error("output low with pulse above frame");

  a_rise_start: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_frame_begin and (s_r.pulse_work != 8'h00)) |-> o_pwm)
    else $error("no high output at frame start");

  a_fall_point: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_r.mode == FPWM_RUN && s_r.pulse_work <= s_r.frame_work &&
     s_r.cnt >= s_r.pulse_work) |-> !o_pwm)
    else $error("output high past pulse width");

  a_frame_len: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_r.fstart && s_r.frame_work == 8'h02) ##1
      (s_r.mode == FPWM_RUN && !i_power_button_pin && !s_r.fstart)
      |=> (s_r.fstart || s_r.mode != FPWM_RUN))
    else $error("two-cycle frame not restarted");

  a_load_work: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_r.fstart |-> (s_r.pulse_work == $past(s_r.pulse_hold) &&
                    s_r.frame_work == $past(s_r.frame_hold)))
    else $error("working copy not loaded at frame start");

  a_stat_set: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_r.fstart |-> s_r.stat)
    else $error("frame start did not set status");

  a_osc_mode: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_power_button_pin |=> (s_r.mode == FPWM_OSC))
    else $error("power button did not select oscillator");
endmodule
`default_nettype wire

// ===== verification/fpwm_load.sv
// External load on the PWM pin: pull-up resistor and a rising-edge counter.
// Assumes the unit drives o_pwm and o_pwm_oe from the same clock.
`default_nettype none
module fpwm_load (
  input  wire logic i_clk_sys,
  input  wire logic i_pwm,
  input  wire logic i_pwm_oe,
  output logic      o_pin,
  output int        o_rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin_q;
  // Released pin is pulled high
  assign o_pin = i_pwm_oe ? i_pwm : 1'b1;
  initial begin
    o_rises = 0;
    pin_q = 1'b1;
  end
  always @(posedge i_clk_sys) begin
    if (o_pin && !pin_q) o_rises <= o_rises + 1;
    pin_q <= o_pin;
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench: Avalon register access, frame timing, irq, osc.
// Assumes the unit is built with a short oscillator half period of 2.
`include "fpwm_consts.svh"
`default_nettype none
module testbench;
  import fpwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        rd   = 1'b0;
  logic        we   = 1'b0;
  logic        btn  = 1'b0;
  logic [17:0] addr = '0;
  logic [31:0] wd   = '0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [1:0]  resp;
  logic [1:0]  r;
  logic        wreq, pwm, oe, fst, irq, pin;
  int          rises, hi, fs, e0;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  int          fl[5] = '{4, 2, 4, 4, 255};
  int          pw[5] = '{2, 1, 0, 5, 254};

  always #20 clk = ~clk;

  fpwm_top #(.OSC_HALF(2)) u_fpwm_top (
    .i_clk_sys(clk), .i_reset(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(we), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_avs_response(resp),
    .i_power_button_pin(btn), .o_pwm(pwm), .o_pwm_oe(oe),
    .o_frame_start(fst), .o_irq(irq));

  fpwm_load u_fpwm_load (
    .i_clk_sys(clk), .i_pwm(pwm), .i_pwm_oe(oe), .o_pin(pin),
    .o_rises(rises));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access; held until waitrequest is seen low
  task automatic acc(input logic w, input logic [15:0] idx,
                     input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    we <= w;
    addr <= {idx, 2'b00};
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    r = resp;
    rd <= 1'b0;
    we <= 1'b0;
  endtask

  // Counts high cycles and frame starts, optionally from a frame start
  task automatic meas(input bit sync, input int n);
    int k;
    k = 0;
    hi = 0;
    fs = 0;
    if (sync) do begin @(negedge clk); k++; end
      while (fst !== 1'b1 && k < 600);
    else @(negedge clk);
    repeat (n) begin
      hi += (pwm === 1'b1);
      fs += (fst === 1'b1);
      @(negedge clk);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    acc(0, `FPWM_IDX_FRAME_LENGTH, 0); chk(q, 32'h0);
    acc(0, `FPWM_IDX_PULSE_WIDTH, 0); chk(q, 32'h0);
    acc(0, `FPWM_IDX_UNIT_STATUS, 0); chk(q[1], 1'b1);
    meas(0, 20); chk(hi, 0); chk(fs, 0);
    chk(irq, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      acc(1, `FPWM_IDX_PULSE_WIDTH, pw[i]);
      acc(1, `FPWM_IDX_FRAME_LENGTH, fl[i]);
      acc(0, `FPWM_IDX_PULSE_WIDTH, 0); chk(q, pw[i]);
      acc(0, `FPWM_IDX_FRAME_LENGTH, 0); chk(q, fl[i]);
      meas(1, 2 * fl[i]);
      chk(fs, 2);
      chk(hi, 2 * (pw[i] > fl[i] ? fl[i] : pw[i]));
    end
    $display("test frames done");
    acc(0, `FPWM_IDX_IRQ_STATUS, 0); chk(q[0], 1'b1);
    chk(irq, 1'b0);
    acc(1, `FPWM_IDX_IRQ_MASK, 1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    acc(1, `FPWM_IDX_FRAME_LENGTH, 1);
    repeat (300) @(negedge clk);
    meas(0, 20); chk(hi, 0); chk(fs, 0);
    acc(1, `FPWM_IDX_IRQ_STATUS, 1);
    acc(0, `FPWM_IDX_IRQ_STATUS, 0); chk(q[0], 1'b0);
    chk(irq, 1'b0);
    acc(0, 16'hFED9, 0); chk(r, 2'b10);
    $display("test irq and powerdown done");
    acc(1, `FPWM_IDX_PULSE_WIDTH, 2);
    acc(1, `FPWM_IDX_FRAME_LENGTH, 4);
    @(posedge clk);
    btn <= 1'b1;
    repeat (10) @(negedge clk);
    e0 = rises;
    repeat (40) @(negedge clk);
    chk(rises - e0 >= 8, 1'b1);
    acc(0, `FPWM_IDX_UNIT_STATUS, 0); chk(q[2], 1'b1);
    @(posedge clk);
    btn <= 1'b0;
    meas(1, 8); chk(hi, 4); chk(fs, 2);
    $display("test power button done");
    finish_test();
  end
endmodule
`default_nettype wire
